// [logic/ssad_pkg.sv]
// Purpose: Shared constants, types and helpers for the sampling converter control block
// Assumes: 100 MHz system clock, eight channels of 16-bit results
// Notes:   Serial read-out and oversampling are outside this block

// ***************************************************************
// Package
// ***************************************************************
package ssad_pkg;

    localparam int NUM_CH = 8;
    localparam int HALF_CH = 4;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int PTR_W = 4;

    // Conversion timing, derived from the clock period
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 4000;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = $clog2(CONV_CYC + 1);

    // Reset values, hold patterns, pointer step and bus enables
    localparam logic [NUM_CH-1:0] HOLD_RST = 8'h00;
    localparam logic [NUM_CH-1:0] HOLD_LOW_SET = 8'h0F;
    localparam logic [NUM_CH-1:0] HOLD_HIGH_SET = 8'hF0;
    localparam logic [NUM_CH-1:0] HOLD_ALL = 8'hFF;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
    localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
    localparam logic [DATA_W-1:0] OE_PAR = 16'hFFFF;
    localparam logic [DATA_W-1:0] OE_BYTE = 16'h00FF;
    localparam logic [DATA_W-1:0] OE_NONE = 16'h0000;

    typedef enum logic [1:0] {SSAD_IF_PAR, SSAD_IF_SER, SSAD_IF_BYTE} ssad_if_t;

    // Mode from the two static select pins; the unlisted 01 falls back to parallel
    function automatic ssad_if_t ssad_decode_if(input logic sel, input logic byte_sel);
        ssad_if_t m;
        m = SSAD_IF_PAR;
        if (sel && byte_sel) begin
            m = SSAD_IF_BYTE;
        end else if (sel) begin
            m = SSAD_IF_SER;
        end
        return m;
    endfunction : ssad_decode_if

    // One byte of a result, upper or lower
    function automatic logic [BYTE_W-1:0] ssad_byte_of(input logic [DATA_W-1:0] w,
                                                       input logic upper);
        logic [BYTE_W-1:0] b;
        b = upper ? w[DATA_W-1:BYTE_W] : w[BYTE_W-1:0];
        return b;
    endfunction : ssad_byte_of

endpackage : ssad_pkg

// [logic/ssad_edge.sv]
// Purpose: Rising and falling edge detector for a synchronous input
// Assumes: Input is already synchronous to sys_clk
// Notes:   Edge pulses are combinational, one cycle wide

`timescale 1ns/100ps
`default_nettype none

module ssad_edge (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sig,
    output logic rise,
    output logic fall
);
    import ssad_pkg::*;

    typedef struct packed {
        logic prev;
    } ssad_edge_t;

    ssad_edge_t st_r;
    ssad_edge_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = sig;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise = sig && !st_r.prev;
    assign fall = !sig && st_r.prev;

    property p_edge_single;
        @(posedge sys_clk) disable iff (!nrst) rise |=> !rise;
    endproperty
    a_edge_single: assert property (p_edge_single) else $error("edge pulse too long");

endmodule : ssad_edge

`default_nettype wire

// [logic/ssad_conv_timer.sv]
// Purpose: Internal conversion timer that owns the busy level
// Assumes: Start pulses while busy are dropped by the caller
// Notes:   Busy stays high exactly CONV_CYC cycles

`timescale 1ns/100ps
`default_nettype none

module ssad_conv_timer (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic start,
    output logic busy,
    output logic done
);
    import ssad_pkg::*;

    typedef struct packed {
        logic busy;
        logic [CNT_W-1:0] cnt;
    } ssad_timer_t;

    ssad_timer_t st_r;
    ssad_timer_t st_nxt;
    logic [CNT_W-1:0] busy_len_r;

    assign done = st_r.busy && (st_r.cnt == CNT_W'(CONV_CYC - 1));
    assign busy = st_r.busy;

    // ***************************************************************
    // Counter
    // ***************************************************************
    always_comb begin
        st_nxt = st_r;
        if (st_r.busy) begin
            if (done) begin
                st_nxt.busy = 1'b0;
                st_nxt.cnt = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end else if (start) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Helper count of busy cycles for checking only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_len_r <= '0;
        end else if (st_r.busy) begin
            busy_len_r <= busy_len_r + 1'b1;
        end else begin
            busy_len_r <= '0;
        end
    end

    property p_busy_len;
        @(posedge sys_clk) disable iff (!nrst) $fell(busy) |-> $past(busy_len_r) == CNT_W'(CONV_CYC - 1);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("conversion length wrong");

    property p_start_busy;
        @(posedge sys_clk) disable iff (!nrst) (start && !busy) |=> busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy did not rise");

endmodule : ssad_conv_timer

`default_nettype wire

// [logic/ssad_conv_ctrl.sv]
// Purpose: Conversion start control and parallel / byte read-out of results
// Assumes: All inputs synchronous to sys_clk; host keeps mode pins static
// Notes:   Analog hold is modelled by capturing chan_sample into a held copy

`timescale 1ns/100ps
`default_nettype none

module ssad_conv_ctrl (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic conv_start_a,
    input wire logic conv_start_b,
    input wire logic [ssad_pkg::NUM_CH-1:0][ssad_pkg::DATA_W-1:0] chan_sample,
    input wire logic iface_select,
    input wire logic byte_mode_select,
    input wire logic high_byte_first,
    input wire logic cs_n,
    input wire logic rd_n,
    output logic busy,
    output logic [ssad_pkg::NUM_CH-1:0] chan_hold,
    output logic [ssad_pkg::DATA_W-1:0] parallel_data_bus_out,
    output logic [ssad_pkg::DATA_W-1:0] parallel_data_bus_oe,
    output logic first_channel_flag_out,
    output logic first_channel_flag_oe,
    output logic serial_out_a,
    output logic serial_out_b,
    output logic serial_out_oe
);
    import ssad_pkg::*;

    typedef enum logic [1:0] {ARM_IDLE, ARM_WAIT_B, ARM_WAIT_A, ARM_CONV} ssad_arm_t;

    typedef struct packed {
        ssad_arm_t arm;
        logic [NUM_CH-1:0] hold;
        logic [NUM_CH-1:0][DATA_W-1:0] held;
        logic [NUM_CH-1:0][DATA_W-1:0] results;
        logic [PTR_W-1:0] ptr;
        logic [DATA_W-1:0] data;
        logic flag;
    } ssad_main_t;

    ssad_main_t st_r;
    ssad_main_t st_nxt;

    logic rise_a;
    logic rise_b;
    logic strobe;
    logic take;
    logic conv_go;
    logic conv_done;
    ssad_if_t mode;
    logic [2:0] chan_idx;
    logic upper_sel;

    // ***************************************************************
    // Edge detection and conversion timer
    // ***************************************************************
    assign strobe = !cs_n && !rd_n;

    ssad_edge u_edge_a (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sig(conv_start_a),
        .rise(rise_a),
        .fall()
    );

    ssad_edge u_edge_b (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sig(conv_start_b),
        .rise(rise_b),
        .fall()
    );

    // Combined strobe edge covers tied select, tied-low select and both separate
    ssad_edge u_edge_rd (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sig(strobe),
        .rise(take),
        .fall()
    );

    ssad_conv_timer u_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(conv_go),
        .busy(busy),
        .done(conv_done)
    );

    // ***************************************************************
    // Mode and word selection
    // ***************************************************************
    assign mode = ssad_decode_if(iface_select, byte_mode_select);

    always_comb begin
        chan_idx = st_r.ptr[2:0];
        upper_sel = 1'b0;
        if (mode == SSAD_IF_BYTE) begin
            chan_idx = st_r.ptr[3:1];
            upper_sel = st_r.ptr[0] ^ high_byte_first;
        end
    end

    // ***************************************************************
    // Next state
    // ***************************************************************
    always_comb begin
        st_nxt = st_r;
        conv_go = 1'b0;
        case (st_r.arm)
            ARM_IDLE: begin
                if (rise_a && rise_b) begin
                    st_nxt.hold = HOLD_ALL;
                    st_nxt.held = chan_sample;
                    st_nxt.arm = ARM_CONV;
                    conv_go = 1'b1;
                end else if (rise_a) begin
                    st_nxt.hold = HOLD_LOW_SET;
                    st_nxt.held[HALF_CH-1:0] = chan_sample[HALF_CH-1:0];
                    st_nxt.arm = ARM_WAIT_B;
                end else if (rise_b) begin
                    st_nxt.hold = HOLD_HIGH_SET;
                    st_nxt.held[NUM_CH-1:HALF_CH] = chan_sample[NUM_CH-1:HALF_CH];
                    st_nxt.arm = ARM_WAIT_A;
                end
            end
            ARM_WAIT_B: begin
                // Skew between the two edges is the host's to bound
                if (rise_b) begin
                    st_nxt.hold = HOLD_ALL;
                    st_nxt.held[NUM_CH-1:HALF_CH] = chan_sample[NUM_CH-1:HALF_CH];
                    st_nxt.arm = ARM_CONV;
                    conv_go = 1'b1;
                end
            end
            ARM_WAIT_A: begin
                if (rise_a) begin
                    st_nxt.hold = HOLD_ALL;
                    st_nxt.held[HALF_CH-1:0] = chan_sample[HALF_CH-1:0];
                    st_nxt.arm = ARM_CONV;
                    conv_go = 1'b1;
                end
            end
            ARM_CONV: begin
                // Starts during a conversion are ignored
                if (conv_done) begin
                    st_nxt.hold = HOLD_RST;
                    st_nxt.results = st_r.held;
                    st_nxt.arm = ARM_IDLE;
                end
            end
            default: begin
                st_nxt.arm = ARM_IDLE;
            end
        endcase

        // Read-out pointer; results only change at busy fall, so reads during
        // busy return the previous set, and split starts do not touch it
        if (conv_done) begin
            st_nxt.ptr = PTR_RST;
        end else if (take && (mode != SSAD_IF_SER)) begin
            if (mode == SSAD_IF_BYTE) begin
                st_nxt.data = {8'h00, ssad_byte_of(st_r.results[chan_idx], upper_sel)};
                st_nxt.ptr = st_r.ptr + PTR_ONE;
            end else begin
                st_nxt.data = st_r.results[chan_idx];
                st_nxt.ptr = {1'b0, st_r.ptr[2:0] + 3'h1};
            end
            st_nxt.flag = (chan_idx == 3'h0);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign chan_hold = st_r.hold;
    assign parallel_data_bus_out = st_r.data;
    assign first_channel_flag_out = st_r.flag;
    assign first_channel_flag_oe = !cs_n;

    // Bus floats whenever either strobe is high, so a select rise floats it
    always_comb begin
        parallel_data_bus_oe = OE_NONE;
        if (strobe && (mode == SSAD_IF_PAR)) begin
            parallel_data_bus_oe = OE_PAR;
        end else if (strobe && (mode == SSAD_IF_BYTE)) begin
            parallel_data_bus_oe = OE_BYTE;
        end
    end

    // Serial shifting lives elsewhere; these lines stay quiet and floated
    assign serial_out_a = 1'b0;
    assign serial_out_b = 1'b0;
    assign serial_out_oe = 1'b0;

    // ***************************************************************
    // Checks
    // ***************************************************************
    property p_joint_hold;
        @(posedge sys_clk) disable iff (!nrst)
            (st_r.arm == ARM_IDLE && rise_a && rise_b) |=> (chan_hold == HOLD_ALL && busy);
    endproperty
    a_joint_hold: assert property (p_joint_hold) else $error("joint start did not hold all");

    property p_track_on_fall;
        @(posedge sys_clk) disable iff (!nrst) $fell(busy) |-> (chan_hold == HOLD_RST);
    endproperty
    a_track_on_fall: assert property (p_track_on_fall) else $error("hold not released");

    property p_split_a;
        @(posedge sys_clk) disable iff (!nrst)
            (st_r.arm == ARM_IDLE && rise_a && !rise_b) |=> (chan_hold == HOLD_LOW_SET && !busy);
    endproperty
    a_split_a: assert property (p_split_a) else $error("start A hold wrong");

    property p_split_late;
        @(posedge sys_clk) disable iff (!nrst)
            (st_r.arm == ARM_WAIT_B && rise_b) |=> busy ##0 (chan_hold == HOLD_ALL);
    endproperty
    a_split_late: assert property (p_split_late) else $error("busy missed later edge");

    property p_float;
        @(posedge sys_clk) disable iff (!nrst) (cs_n || rd_n) |-> (parallel_data_bus_oe == OE_NONE);
    endproperty
    a_float: assert property (p_float) else $error("bus driven while idle");

    property p_first_after_busy;
        @(posedge sys_clk) disable iff (!nrst)
            (take && !busy && mode == SSAD_IF_PAR && st_r.ptr == PTR_RST)
            |=> (parallel_data_bus_out == st_r.results[0] && first_channel_flag_out);
    endproperty
    a_first_after_busy: assert property (p_first_after_busy) else $error("first read not ch1");

    // Restarting the pointer here is what makes the next read channel one
    property p_ptr_clear;
        @(posedge sys_clk) disable iff (!nrst) $fell(busy) |-> (st_r.ptr == PTR_RST);
    endproperty
    a_ptr_clear: assert property (p_ptr_clear) else $error("read pointer not restarted");

    property p_byte_lanes;
        @(posedge sys_clk) disable iff (!nrst)
            (strobe && mode == SSAD_IF_BYTE) |-> (parallel_data_bus_oe == OE_BYTE);
    endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("upper lanes driven");

    property p_byte_upper_zero;
        @(posedge sys_clk) disable iff (!nrst)
            (take && !conv_done && mode == SSAD_IF_BYTE)
            |=> (parallel_data_bus_out[DATA_W-1:BYTE_W] == 8'h00);
    endproperty
    a_byte_upper_zero: assert property (p_byte_upper_zero) else $error("upper byte not zero");

    property p_flag_two_bytes;
        @(posedge sys_clk) disable iff (!nrst)
            (take && !conv_done && mode == SSAD_IF_BYTE && st_r.ptr == PTR_ONE)
            |=> first_channel_flag_out;
    endproperty
    a_flag_two_bytes: assert property (p_flag_two_bytes) else $error("flag dropped early");

    property p_results_stable;
        @(posedge sys_clk) disable iff (!nrst) busy |=> $stable(st_r.results) || $fell(busy);
    endproperty
    a_results_stable: assert property (p_results_stable) else $error("results changed in busy");

endmodule : ssad_conv_ctrl

`default_nettype wire

// [bench/ssad_host_model.sv]
// Purpose: Host model that drives the start inputs and the read strobes
// Assumes: Strobes change just after rising edges of sys_clk
// Notes: No oversampling here, so split starts are always allowed

`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Host model
// ****************************************
module ssad_host_model (
    input wire logic sys_clk,
    input wire logic [ssad_pkg::DATA_W-1:0] bus_out,
    input wire logic [ssad_pkg::DATA_W-1:0] bus_oe,
    input wire logic flag_out,
    input wire logic flag_oe,
    output logic conv_start_a,
    output logic conv_start_b,
    output logic cs_n,
    output logic rd_n
);
    import ssad_pkg::*;

    logic [DATA_W-1:0] bus_wire;
    logic flag_wire;

    // Floating lines read inverted, so a released bus never passes for data
    assign bus_wire = (bus_out & bus_oe) | (~bus_out & ~bus_oe);
    assign flag_wire = flag_oe ? flag_out : ~flag_out;

    initial begin
        conv_start_a = 1'b0;
        conv_start_b = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
    end

    // Callers keep the gap between split starts to a few cycles
    task automatic pulse(input logic a, input logic b);
        @(posedge sys_clk);
        conv_start_a <= a;
        conv_start_b <= b;
        @(posedge sys_clk);
        conv_start_a <= 1'b0;
        conv_start_b <= 1'b0;
    endtask : pulse

    // Style 0 pulses both strobes, 1 keeps select low, 2 lifts select alone
    task automatic read(input int style, output logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] oe, output logic f,
                        output logic [DATA_W-1:0] oe_off);
        @(posedge sys_clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        d = bus_wire;
        oe = bus_oe;
        f = flag_wire;
        @(posedge sys_clk);
        if (style == 2) begin
            cs_n <= 1'b1;
        end else begin
            rd_n <= 1'b1;
        end
        if (style == 0) begin
            cs_n <= 1'b1;
        end
        #1;
        oe_off = bus_oe;
    endtask : read

endmodule : ssad_host_model

`default_nettype wire

// [bench/simsample_adc_conv_parallel_read_tb.sv]
// Purpose: Self-checking bench for the sampling converter control block
// Assumes: Host model owns starts and strobes; bench owns samples and mode pins
// Notes: Serial mode is only checked for keeping off the parallel bus

`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Bench
// ****************************************
module simsample_adc_conv_parallel_read_tb;
    import ssad_pkg::*;

    typedef logic [NUM_CH-1:0][DATA_W-1:0] ssad_set_t;

    logic sys_clk;
    logic nrst;
    logic iface_select;
    logic byte_mode_select;
    logic high_byte_first;
    ssad_set_t chan_sample;
    ssad_set_t prev_s;
    logic conv_start_a;
    logic conv_start_b;
    logic cs_n;
    logic rd_n;
    logic busy;
    logic [NUM_CH-1:0] chan_hold;
    logic [DATA_W-1:0] bus_out;
    logic [DATA_W-1:0] bus_oe;
    logic flag_out;
    logic flag_oe;
    int mismatches;
    int comparisons;
    int cycles;

    ssad_conv_ctrl i_ssad_conv_ctrl (
        .sys_clk(sys_clk), .nrst(nrst), .conv_start_a(conv_start_a),
        .conv_start_b(conv_start_b), .chan_sample(chan_sample),
        .iface_select(iface_select), .byte_mode_select(byte_mode_select),
        .high_byte_first(high_byte_first), .cs_n(cs_n), .rd_n(rd_n), .busy(busy),
        .chan_hold(chan_hold), .parallel_data_bus_out(bus_out),
        .parallel_data_bus_oe(bus_oe), .first_channel_flag_out(flag_out),
        .first_channel_flag_oe(flag_oe), .serial_out_a(), .serial_out_b(),
        .serial_out_oe()
    );

    ssad_host_model i_ssad_host_model (
        .sys_clk(sys_clk), .bus_out(bus_out), .bus_oe(bus_oe), .flag_out(flag_out),
        .flag_oe(flag_oe), .conv_start_a(conv_start_a), .conv_start_b(conv_start_b),
        .cs_n(cs_n), .rd_n(rd_n)
    );

    always #5 sys_clk = ~sys_clk;

    // Ceiling well above the five conversions and their reads
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic check_word(input string what, input logic [DATA_W-1:0] exp,
                              input logic [DATA_W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    function automatic ssad_set_t make_set(input logic [DATA_W-1:0] base);
        ssad_set_t v;
        for (int i = 0; i < NUM_CH; i++) begin
            v[i] = base + DATA_W'(i) * 16'h1357;
        end
        return v;
    endfunction : make_set

    // Waits for busy, times it, and scrambles the inputs mid-conversion
    task automatic conv_done(input logic [NUM_CH-1:0] hold_exp, input logic timed);
        int n;
        n = 0;
        #1;
        while (busy !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check_bit("busy rise", 1'b1, busy);
        check_word("hold busy", DATA_W'(hold_exp), DATA_W'(chan_hold));
        n = 1;
        while (busy === 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            if (n == 3) begin
                chan_sample <= ~chan_sample;
            end
            #1;
            n++;
        end
        if (timed) begin
            check_word("busy cycles", DATA_W'(CONV_CYC), DATA_W'(n - 1));
        end
        check_word("hold track", DATA_W'(HOLD_RST), DATA_W'(chan_hold));
    endtask : conv_done

    task automatic rd_chk(input int style, input logic [DATA_W-1:0] exp, input logic fl,
                          input logic [DATA_W-1:0] oe_exp);
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] oe;
        logic [DATA_W-1:0] oe_off;
        logic f;
        i_ssad_host_model.read(style, d, oe, f, oe_off);
        check_word("bus data", exp, d & oe_exp);
        check_word("bus enable", oe_exp, oe);
        check_word("bus released", OE_NONE, oe_off);
        if (oe_exp != OE_NONE) begin
            check_bit("first flag", fl, f);
        end
    endtask : rd_chk

    task automatic t_joint();
        prev_s = make_set(16'h8001);
        @(posedge sys_clk);
        chan_sample <= prev_s;
        i_ssad_host_model.pulse(1'b1, 1'b1);
        conv_done(HOLD_ALL, 1'b1);
        for (int i = 0; i < NUM_CH; i++) begin
            rd_chk(0, prev_s[i], i == 0, OE_PAR);
        end
    endtask : t_joint

    task automatic t_split();
        ssad_set_t s;
        ssad_set_t t;
        s = make_set(16'h0F0F);
        t = make_set(16'hC3A5);
        @(posedge sys_clk);
        chan_sample <= s;
        i_ssad_host_model.pulse(1'b1, 1'b0);
        repeat (3) @(posedge sys_clk);
        chan_sample <= t;
        #1;
        check_bit("busy after a", 1'b0, busy);
        check_word("hold after a", DATA_W'(HOLD_LOW_SET), DATA_W'(chan_hold));
        i_ssad_host_model.pulse(1'b0, 1'b1);
        conv_done(HOLD_ALL, 1'b1);
        for (int i = 0; i < NUM_CH; i++) begin
            prev_s[i] = (i < HALF_CH) ? s[i] : t[i];
            rd_chk((i == NUM_CH - 1) ? 2 : 1, prev_s[i], i == 0, OE_PAR);
        end
    endtask : t_split

    task automatic t_busy_read();
        ssad_set_t s;
        s = make_set(16'h7FFF);
        rd_chk(0, prev_s[0], 1'b1, OE_PAR);
        rd_chk(0, prev_s[1], 1'b0, OE_PAR);
        @(posedge sys_clk);
        chan_sample <= s;
        i_ssad_host_model.pulse(1'b1, 1'b1);
        rd_chk(0, prev_s[2], 1'b0, OE_PAR);
        conv_done(HOLD_ALL, 1'b0);
        for (int i = 0; i <= NUM_CH; i++) begin
            rd_chk(0, s[i % NUM_CH], i % NUM_CH == 0, OE_PAR);
        end
    endtask : t_busy_read

    task automatic t_byte();
        ssad_set_t s;
        logic up;
        s = make_set(16'hA55A);
        @(posedge sys_clk);
        iface_select <= 1'b1;
        byte_mode_select <= 1'b1;
        chan_sample <= s;
        i_ssad_host_model.pulse(1'b1, 1'b1);
        conv_done(HOLD_ALL, 1'b0);
        for (int h = 1; h >= 0; h--) begin
            @(posedge sys_clk);
            high_byte_first <= h[0];
            for (int k = 0; k < 2 * NUM_CH; k++) begin
                up = ((k % 2) == 0) == (h == 1);
                rd_chk(0, {8'h00, up ? s[k / 2][15:8] : s[k / 2][7:0]}, k < 2,
                       OE_BYTE);
            end
        end
    endtask : t_byte

    // Serial reads leave the pointer alone, so the unlisted 01 code resumes at channel one
    task automatic t_serial();
        ssad_set_t s;
        s = make_set(16'hA55A);
        @(posedge sys_clk);
        byte_mode_select <= 1'b0;
        rd_chk(0, OE_NONE, 1'b0, OE_NONE);
        @(posedge sys_clk);
        iface_select <= 1'b0;
        byte_mode_select <= 1'b1;
        rd_chk(0, s[0], 1'b1, OE_PAR);
    endtask : t_serial

    // Reset in mid-conversion must drop busy and hold and clear the results
    task automatic t_reset();
        @(posedge sys_clk);
        byte_mode_select <= 1'b0;
        i_ssad_host_model.pulse(1'b1, 1'b1);
        repeat (5) @(posedge sys_clk);
        #1;
        check_bit("busy before reset", 1'b1, busy);
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check_bit("busy mid reset", 1'b0, busy);
        check_word("hold mid reset", DATA_W'(HOLD_RST), DATA_W'(chan_hold));
        rd_chk(0, DATA_RST, 1'b1, OE_PAR);
    endtask : t_reset

    initial begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        iface_select = 1'b0;
        byte_mode_select = 1'b0;
        high_byte_first = 1'b0;
        chan_sample = '0;
        prev_s = '0;
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check_bit("busy reset", 1'b0, busy);
        check_word("hold reset", DATA_W'(HOLD_RST), DATA_W'(chan_hold));
        t_joint();
        t_split();
        t_busy_read();
        t_byte();
        t_serial();
        t_reset();
        stop_test();
    end

endmodule : simsample_adc_conv_parallel_read_tb

`default_nettype wire
